// file: logic/tsr_cfg.svh
// register map, field positions, reset values and constants of the slot routing block
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH

`define TSR_ADDR_ROUTE_SEL      8'h09
`define TSR_ADDR_A_LOW_MASK     8'h0A
`define TSR_ADDR_A_HIGH_MASK    8'h0B
`define TSR_ADDR_B_LOW_MASK     8'h0C
`define TSR_ADDR_B_HIGH_MASK    8'h0D
`define TSR_ADDR_TRACK_CTL      8'h0E
`define TSR_ADDR_STATUS         8'h1E
`define TSR_ADDR_TRACK_CFG      8'h1F

`define TSR_MAIN_SEL_MSB        5
`define TSR_MAIN_SEL_LSB        3
`define TSR_LL_SEL_MSB          2
`define TSR_LL_SEL_LSB          0
`define TSR_REF_MODE_BIT        7
`define TSR_OFFSET_MSB          6
`define TSR_OFFSET_LSB          4
`define TSR_GDELAY_MSB          3
`define TSR_GDELAY_LSB          0
`define TSR_CFG_FILTER_BIT      3
`define TSR_CFG_SRC_MSB         2
`define TSR_CFG_SRC_LSB         0

`define TSR_RST_ROUTE_SEL       8'h00
`define TSR_RST_MASK            8'hFF
`define TSR_RST_TRACK_CTL       8'h00
`define TSR_RST_TRACK_CFG       8'h00

`define TSR_SRC_MASKED          3'h4
`define TSR_SLOTS_PER_FRAME     16
`define TSR_FULL_SCALE          24'h7FFFFF
`define TSR_NEG_FULL_SCALE      24'h800001
`define TSR_OFFSET_STEP         24'h03D70A

`endif

// file: logic/tsr_pkg.sv
// types shared by the slot routing block
package tsr_pkg;

  typedef logic [23:0] tsr_sample_t;

  // one slot time of both input streams
  typedef struct packed {
    logic        first_slot;
    tsr_sample_t data_b;
    tsr_sample_t data_a;
  } tsr_slot_s;

  // one routed frame handed to the converter side
  typedef struct packed {
    tsr_sample_t       track;
    logic [3:0][23:0]  low_lat;
    logic [3:0][23:0]  main;
  } tsr_frame_s;

endpackage

// file: logic/tsr_slot_router.sv
// slot routing, tracking mask and tracking reference control with register port
`include "tsr_cfg.svh"
`timescale 1ns/1ps

module tsr_slot_router (
  // clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                reset_in,
  // register port
  input  wire logic [7:0]          reg_addr_in,
  input  wire logic [7:0]          reg_wr_data_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [7:0]          reg_rd_data_out,
  // slot stream from the serial inputs
  input  wire tsr_pkg::tsr_slot_s  slot_in,
  input  wire logic                slot_valid_in,
  output logic                     slot_ready_out,
  // routed frames toward the converters
  output tsr_pkg::tsr_frame_s      frame_out,
  output logic                     frame_valid_out,
  input  wire logic                frame_ready_in,
  // static controls for the converter side
  output logic      [3:0]          group_delay_out
);

  // register state
  logic [7:0] route_sel_ff;
  logic [7:0] a_low_mask_ff;
  logic [7:0] a_high_mask_ff;
  logic [7:0] b_low_mask_ff;
  logic [7:0] b_high_mask_ff;
  logic [7:0] track_ctl_ff;
  logic [3:0] track_cfg_ff;
  logic [7:0] rd_data_ff;

  // frame assembly state
  logic [3:0]               slot_idx_ff;
  logic [3:0][23:0]         main_ff;
  logic [3:0][23:0]         ll_ff;
  logic [22:0]              peak_ff;
  tsr_pkg::tsr_sample_t     fixed_ff;

  // two-entry output buffer
  tsr_pkg::tsr_frame_s      ent0_ff;
  tsr_pkg::tsr_frame_s      ent1_ff;
  logic [1:0]               cnt_ff;
  logic [1:0]               nxt_cnt;
  logic                     in_ready_ff;

  // decoded fields
  logic [2:0]  main_sel;
  logic [2:0]  ll_sel;
  logic        ref_mode;
  logic [2:0]  dc_offset;
  logic        track_filter_mode;
  logic [2:0]  track_src_sel;
  logic [15:0] mask_a;
  logic [15:0] mask_b;

  assign main_sel          = route_sel_ff[`TSR_MAIN_SEL_MSB:`TSR_MAIN_SEL_LSB];
  assign ll_sel            = route_sel_ff[`TSR_LL_SEL_MSB:`TSR_LL_SEL_LSB];
  assign ref_mode          = track_ctl_ff[`TSR_REF_MODE_BIT];
  assign dc_offset         = track_ctl_ff[`TSR_OFFSET_MSB:`TSR_OFFSET_LSB];
  assign track_filter_mode = track_cfg_ff[`TSR_CFG_FILTER_BIT];
  assign track_src_sel     = track_cfg_ff[`TSR_CFG_SRC_MSB:`TSR_CFG_SRC_LSB];
  // slot 1 sits in bit 15 of each joined mask
  assign mask_a            = {a_low_mask_ff, a_high_mask_ff};
  assign mask_b            = {b_low_mask_ff, b_high_mask_ff};

  // route select; reserved bits 7:6 are never stored, so they read back 0
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      route_sel_ff <= `TSR_RST_ROUTE_SEL;
    end else if (reg_wr_in && reg_addr_in == `TSR_ADDR_ROUTE_SEL) begin
      route_sel_ff <= {2'h0, reg_wr_data_in[5:0]};
    end
  end

  // slot masks reset to all ones, so with the masked source nothing is tracked until software opens slots
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      a_low_mask_ff <= `TSR_RST_MASK;
    end else if (reg_wr_in && reg_addr_in == `TSR_ADDR_A_LOW_MASK) begin
      a_low_mask_ff <= reg_wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      a_high_mask_ff <= `TSR_RST_MASK;
    end else if (reg_wr_in && reg_addr_in == `TSR_ADDR_A_HIGH_MASK) begin
      a_high_mask_ff <= reg_wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      b_low_mask_ff <= `TSR_RST_MASK;
    end else if (reg_wr_in && reg_addr_in == `TSR_ADDR_B_LOW_MASK) begin
      b_low_mask_ff <= reg_wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      b_high_mask_ff <= `TSR_RST_MASK;
    end else if (reg_wr_in && reg_addr_in == `TSR_ADDR_B_HIGH_MASK) begin
      b_high_mask_ff <= reg_wr_data_in;
    end
  end

  // the group delay field is taken as written, the
  // controller is trusted to change it only with the converters idle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      track_ctl_ff <= `TSR_RST_TRACK_CTL;
    end else if (reg_wr_in && reg_addr_in == `TSR_ADDR_TRACK_CTL) begin
      track_ctl_ff <= reg_wr_data_in;
    end
  end

  // tracking path config; upper nibble is not stored
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      track_cfg_ff <= 4'(`TSR_RST_TRACK_CFG);
    end else if (reg_wr_in && reg_addr_in == `TSR_ADDR_TRACK_CFG) begin
      track_cfg_ff <= reg_wr_data_in[3:0];
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_data_ff <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `TSR_ADDR_ROUTE_SEL:   rd_data_ff <= route_sel_ff;
        `TSR_ADDR_A_LOW_MASK:  rd_data_ff <= a_low_mask_ff;
        `TSR_ADDR_A_HIGH_MASK: rd_data_ff <= a_high_mask_ff;
        `TSR_ADDR_B_LOW_MASK:  rd_data_ff <= b_low_mask_ff;
        `TSR_ADDR_B_HIGH_MASK: rd_data_ff <= b_high_mask_ff;
        `TSR_ADDR_TRACK_CTL:   rd_data_ff <= track_ctl_ff;
        `TSR_ADDR_TRACK_CFG:   rd_data_ff <= {4'h0, track_cfg_ff};
        `TSR_ADDR_STATUS:      rd_data_ff <= {slot_idx_ff, 1'b0, in_ready_ff, cnt_ff};
        default:               rd_data_ff <= 8'h00;
      endcase
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // per-slot tracking contributions
  logic                 accept;
  logic [3:0]           cur_idx;
  logic                 last_slot;
  logic [22:0]          mag_a;
  logic [22:0]          mag_b;
  logic [22:0]          slot_peak;
  logic [22:0]          frame_peak;
  tsr_pkg::tsr_sample_t frame_fixed;
  tsr_pkg::tsr_sample_t track_word;

  function automatic logic [22:0] tsr_mag(input tsr_pkg::tsr_sample_t s);
    logic [23:0] neg;
    neg = 24'(~s + 24'h000001);
    if (!s[23]) begin
      tsr_mag = s[22:0];
    end else if (neg[23]) begin
      tsr_mag = 23'h7FFFFF;
    end else begin
      tsr_mag = neg[22:0];
    end
  endfunction

  // signed add with clamp to the symmetric full-scale range
  function automatic tsr_pkg::tsr_sample_t tsr_add_sat(input tsr_pkg::tsr_sample_t a,
                                                      input tsr_pkg::tsr_sample_t b);
    logic [24:0] sum;
    sum = {a[23], a} + {b[23], b};
    if (sum[24:23] == 2'b01) begin
      tsr_add_sat = `TSR_FULL_SCALE;
    end else if (sum[24:23] == 2'b10 || sum[23:0] == 24'h800000) begin
      tsr_add_sat = `TSR_NEG_FULL_SCALE;
    end else begin
      tsr_add_sat = sum[23:0];
    end
  endfunction

  assign accept    = slot_valid_in && in_ready_ff;
  // a first-slot marker realigns the frame
  assign cur_idx   = slot_in.first_slot ? 4'h0 : slot_idx_ff;
  assign last_slot = (cur_idx == 4'(`TSR_SLOTS_PER_FRAME - 1));
  assign mag_a     = tsr_mag(slot_in.data_a);
  assign mag_b     = tsr_mag(slot_in.data_b);

  always_comb begin
    slot_peak = 23'h000000;
    // only clear mask bits contribute, from either stream
    if (!mask_a[4'hF - cur_idx] && mag_a > slot_peak) begin
      slot_peak = mag_a;
    end
    if (!mask_b[4'hF - cur_idx] && mag_b > slot_peak) begin
      slot_peak = mag_b;
    end
    frame_peak = (cur_idx == 4'h0) ? slot_peak : ((slot_peak > peak_ff) ? slot_peak : peak_ff);
  end

  // fixed codes take the first slot of their stream A group
  assign frame_fixed = (cur_idx == {track_src_sel[1:0], 2'b00}) ? slot_in.data_a : fixed_ff;

  always_comb begin
    tsr_pkg::tsr_sample_t base;
    tsr_pkg::tsr_sample_t offs;
    base = 24'h000000;
    offs = 24'(dc_offset * `TSR_OFFSET_STEP);
    if (track_src_sel == `TSR_SRC_MASKED) begin
      base = {1'b0, frame_peak};
    end else begin
      base = frame_fixed;
    end
    if (track_filter_mode) begin
      // reference at full scale: output falls as the envelope rises
      if (ref_mode) begin
        base = 24'(`TSR_FULL_SCALE - base);
      end
    end else if (ref_mode) begin
      base = tsr_add_sat(24'h000000, 24'(~base + 24'h000001));
    end
    track_word = tsr_add_sat(base, offs);
  end

  // frame assembly
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      slot_idx_ff <= 4'h0;
      peak_ff     <= 23'h000000;
      fixed_ff    <= 24'h000000;
    end else if (accept) begin
      slot_idx_ff <= last_slot ? 4'h0 : 4'(cur_idx + 4'h1);
      peak_ff     <= frame_peak;
      fixed_ff    <= frame_fixed;
    end
  end

  // a slot lands in channel idx[1:0] when its group matches the selector
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      main_ff <= '0;
      ll_ff   <= '0;
    end else if (accept) begin
      if (cur_idx[3:2] == main_sel[1:0]) begin
        main_ff[cur_idx[1:0]] <= main_sel[2] ? slot_in.data_b : slot_in.data_a;
      end
      if (cur_idx[3:2] == ll_sel[1:0]) begin
        ll_ff[cur_idx[1:0]] <= ll_sel[2] ? slot_in.data_b : slot_in.data_a;
      end
    end
  end

  // the frame is complete once slot 16 arrives; it carries the last slot too
  tsr_pkg::tsr_frame_s new_frame;
  logic                push;
  logic                pop;

  always_comb begin
    new_frame         = '0;
    new_frame.main    = main_ff;
    new_frame.low_lat = ll_ff;
    new_frame.track   = track_word;
    if (cur_idx[3:2] == main_sel[1:0]) begin
      new_frame.main[cur_idx[1:0]] = main_sel[2] ? slot_in.data_b : slot_in.data_a;
    end
    if (cur_idx[3:2] == ll_sel[1:0]) begin
      new_frame.low_lat[cur_idx[1:0]] = ll_sel[2] ? slot_in.data_b : slot_in.data_a;
    end
  end

  assign push    = accept && last_slot;
  assign pop     = frame_valid_out && frame_ready_in;
  assign nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});

  // input ready is registered from the next fill level, so it never admits a
  // frame into a full buffer; costs one bubble after the buffer drains
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_ff      <= 2'h0;
      in_ready_ff <= 1'b0;
    end else begin
      cnt_ff      <= nxt_cnt;
      in_ready_ff <= (nxt_cnt < 2'h2);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ent0_ff <= '0;
      ent1_ff <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_ff == 2'h0) begin
            ent0_ff <= new_frame;
          end else begin
            ent1_ff <= new_frame;
          end
        end
        2'b01: begin
          ent0_ff <= ent1_ff;
        end
        2'b11: begin
          if (cnt_ff == 2'h1) begin
            ent0_ff <= new_frame;
          end else begin
            ent0_ff <= ent1_ff;
            ent1_ff <= new_frame;
          end
        end
        default: ;
      endcase
    end
  end

  // outputs
  logic       valid_ff;
  logic [3:0] gdelay_ff;

  // valid follows the next fill level so it rises with the entry it flags
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= (nxt_cnt != 2'h0);
    end
  end

  // registered copy keeps the output straight from a flip-flop, one cycle late
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      gdelay_ff <= 4'h0;
    end else begin
      gdelay_ff <= track_ctl_ff[`TSR_GDELAY_MSB:`TSR_GDELAY_LSB];
    end
  end

  assign reg_rd_data_out = rd_data_ff;
  assign slot_ready_out  = in_ready_ff;
  assign frame_out       = ent0_ff;
  assign frame_valid_out = valid_ff;
  assign group_delay_out = gdelay_ff;

endmodule

// file: sim/tsr_slot_router_sva.sv
// port-level checks for the slot router
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_slot_router_sva (
  // clock and reset
  input wire logic                core_clk_in,
  input wire logic                reset_in,
  // register port
  input wire logic [7:0]          reg_addr_in,
  input wire logic [7:0]          reg_wr_data_in,
  input wire logic                reg_wr_in,
  input wire logic                reg_rd_in,
  input wire logic [7:0]          reg_rd_data_out,
  // stream side
  input wire logic                slot_ready_out,
  input wire tsr_pkg::tsr_frame_s frame_out,
  input wire logic                frame_valid_out,
  input wire logic                frame_ready_in,
  input wire logic [3:0]          group_delay_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  a_read_idle: assert property (
    !reg_rd_in |=> reg_rd_data_out == 8'h00) else $error("read data outside read cycle");
  a_unmapped_zero: assert property (
    reg_rd_in && reg_addr_in > `TSR_ADDR_TRACK_CFG |=> reg_rd_data_out == 8'h00) else $error("unmapped read");
  a_reserved_zero: assert property (
    reg_rd_in && reg_addr_in == `TSR_ADDR_ROUTE_SEL |=> reg_rd_data_out[7:6] == 2'b00) else $error("reserved bits");
  a_mask_readback: assert property (
    reg_wr_in && reg_addr_in == `TSR_ADDR_A_LOW_MASK ##1 reg_rd_in && reg_addr_in == `TSR_ADDR_A_LOW_MASK
    |=> reg_rd_data_out == $past(reg_wr_data_in, 2)) else $error("mask readback");
  a_delay_copy: assert property (
    reg_wr_in && reg_addr_in == `TSR_ADDR_TRACK_CTL |-> ##2 group_delay_out == 4'($past(reg_wr_data_in, 2)))
    else $error("group delay copy");
  a_reset_quiet: assert property (
    $past(reset_in) |-> !slot_ready_out && !frame_valid_out && group_delay_out == 4'h0) else $error("reset state");
  a_ready_wakes: assert property (
    $fell(reset_in) |=> slot_ready_out) else $error("slot ready late");
  a_frame_holds: assert property (
    frame_valid_out && !frame_ready_in |=> frame_valid_out && $stable(frame_out)) else $error("frame dropped");
endmodule

bind tsr_slot_router tsr_slot_router_sva u_sva (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_data_in(reg_wr_data_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rd_data_out(reg_rd_data_out), .slot_ready_out(slot_ready_out),
  .frame_out(frame_out), .frame_valid_out(frame_valid_out), .frame_ready_in(frame_ready_in),
  .group_delay_out(group_delay_out));

// file: sim/tsr_slot_source.sv
// behavioural tdm source feeding one 16-slot frame per start pulse
`timescale 1ns/1ps
module tsr_slot_source #(
  parameter logic [23:0] SEED_B = 24'h000200
) (
  // clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          reset_in,
  // control
  input  wire logic          go_in,
  input  wire logic [23:0]   seed_a_in,
  // slot stream
  output tsr_pkg::tsr_slot_s slot_out,
  output logic               slot_valid_out,
  input  wire logic          slot_ready_in
);
  logic [4:0] num_ff;
  function automatic tsr_pkg::tsr_slot_s mk(input logic first, input logic [4:0] n);
    mk = {first, SEED_B + {19'h00, n}, seed_a_in + {19'h00, n}};
  endfunction
  // idle lines toggle between the last word and its inverse so stale data never looks valid
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      slot_valid_out <= 1'b0;
      num_ff <= 5'h01;
      slot_out <= '0;
    end else if (!slot_valid_out) begin
      slot_valid_out <= go_in;
      num_ff <= 5'h01;
      slot_out <= go_in ? mk(1'b1, 5'h01) : ~slot_out;
    end else if (slot_ready_in) begin
      slot_valid_out <= (num_ff != 5'h10);
      num_ff <= num_ff + 5'h01;
      slot_out <= (num_ff == 5'h10) ? ~slot_out : mk(1'b0, num_ff + 5'h01);
    end
  end
endmodule

// file: sim/tb_tdm_slot_routing_and_tracking_mask.sv
// self-checking bench for the slot routing and tracking mask block
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tb_tdm_slot_routing_and_tracking_mask;
  localparam logic [23:0] SA = 24'h000100;
  localparam logic [23:0] SB = 24'h000200;
  // masks for 0x0A..0x0D high to low, then the tracking word each gives
  localparam logic [31:0] MASKS [7] = '{32'hFFFFFFFF, 32'h7FFFFFFF, 32'hFFFEFFFF, 32'hFFFFBFFF,
                                        32'hFFFFFFFE, 32'hFE7FFFFF, 32'hFFFFFFFF};
  localparam logic [23:0] TRACK [7] = '{24'h0, 24'h101, 24'h110, 24'h202, 24'h210, 24'h109, 24'h101};
  // path config, control, tracking word, group delay
  // the last entry uses source code 101, which acts as fixed group 1
  localparam logic [43:0] REFS [5]  = '{{8'h08, 8'h80, 24'h7FFEFE, 4'h0}, {8'h00, 8'h80, 24'hFFFEFF, 4'h0},
                                        {8'h08, 8'h1A, 24'h03D80B, 4'hA}, {8'h08, 8'h7F, 24'h1AE247, 4'hF},
                                        {8'h0D, 8'h00, 24'h000105, 4'h0}};
  logic                clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, fready = 1'b0;
  logic [7:0]          addr = 8'h00, wdata = 8'h00, rdata;
  logic [23:0]         seed_a = SA;
  logic [3:0]          gdelay;
  logic                sready, svalid, fvalid;
  tsr_pkg::tsr_slot_s  slot;
  tsr_pkg::tsr_frame_s frame;
  int                  error_cnt = 0, samples_checked = 0;

  tsr_slot_router u_dut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_data_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rd_data_out(rdata), .slot_in(slot), .slot_valid_in(svalid),
    .slot_ready_out(sready), .frame_out(frame), .frame_valid_out(fvalid), .frame_ready_in(fready),
    .group_delay_out(gdelay));
  tsr_slot_source #(.SEED_B(SB)) u_src (.core_clk_in(clk), .reset_in(rst), .go_in(go), .seed_a_in(seed_a),
    .slot_out(slot), .slot_valid_out(svalid), .slot_ready_in(sready));

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus cycle; read data is registered, so it is taken just after the strobe's edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    #1;
    q = rdata;
  endtask
  task automatic send(input logic wait_done);
    logic [7:0] q;
    fready <= 1'b0;
    bus(1'b0, 1'b0, 8'h00, 8'h00, q);
    go <= 1'b1;
    @(posedge clk);
    #1;
    go <= 1'b0;
    for (int n = 0; n < 100 && wait_done; n++) begin
      @(posedge clk);
      #1;
      if (svalid !== 1'b1) break;
    end
  endtask
  // ready stays up afterwards; the frame is captured before the edge that hands it over
  task automatic take(output tsr_pkg::tsr_frame_s f);
    fready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk);
      if (fvalid === 1'b1) break;
    end
    chk("frame valid", 24'(fvalid), 24'h1);
    f = frame;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [23:0] exp_slot(input logic [2:0] code, input int i);
    return (code[2] ? SB : SA) + 24'({code[1:0], 2'b00}) + 24'(i + 1);
  endfunction

  task automatic t_reset();
    logic [7:0] q;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 1'b1, (i < 6) ? 8'(9 + i) : ((i == 6) ? 8'h1F : 8'h30), 8'h00, q);
      chk("reset value", 24'(q), (i > 0 && i < 5) ? 24'hFF : 24'h0);
    end
    chk("slot ready", 24'(sready), 24'h1);
    $display("reset test done");
  endtask
  task automatic t_route();
    logic [7:0] q;
    logic [2:0] c;
    tsr_pkg::tsr_frame_s f;
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      bus(1'b1, 1'b0, `TSR_ADDR_ROUTE_SEL, {2'b11, c, ~c}, q);
      bus(1'b0, 1'b1, `TSR_ADDR_ROUTE_SEL, 8'h00, q);
      chk("route select", 24'(q), 24'({2'b00, c, ~c}));
      send(1'b1);
      take(f);
      for (int i = 0; i < 4; i++) begin
        chk("main path", f.main[i], exp_slot(c, i));
        chk("low latency path", f.low_lat[i], exp_slot(~c, i));
      end
    end
    $display("routing test done");
  endtask
  task automatic t_mask();
    logic [7:0] q;
    logic [7:0] m;
    tsr_pkg::tsr_frame_s f;
    for (int i = 0; i < 7; i++) begin
      // the last case uses a fixed source code, where masks must not matter
      bus(1'b1, 1'b0, `TSR_ADDR_TRACK_CFG, (i == 6) ? 8'h08 : 8'h0C, q);
      for (int j = 0; j < 4; j++) begin
        m = MASKS[i][31 - 8 * j -: 8];
        bus(1'b1, 1'b0, 8'(`TSR_ADDR_A_LOW_MASK + j), m, q);
        bus(1'b0, 1'b1, 8'(`TSR_ADDR_A_LOW_MASK + j), 8'h00, q);
        chk("slot mask", 24'(q), 24'(m));
      end
      send(1'b1);
      take(f);
      chk("tracking word", f.track, TRACK[i]);
    end
    $display("mask test done");
  endtask
  task automatic t_ref();
    logic [7:0] q;
    tsr_pkg::tsr_frame_s f;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 1'b0, `TSR_ADDR_TRACK_CFG, REFS[i][43:36], q);
      // group delay is only rewritten between frames, with the stream idle
      bus(1'b1, 1'b0, `TSR_ADDR_TRACK_CTL, REFS[i][35:28], q);
      send(1'b1);
      take(f);
      chk("tracking word", f.track, REFS[i][27:4]);
      chk("group delay", 24'(gdelay), 24'(REFS[i][3:0]));
    end
    $display("reference test done");
  endtask
  task automatic t_buffer();
    logic [7:0] q;
    tsr_pkg::tsr_frame_s f;
    bus(1'b1, 1'b0, `TSR_ADDR_ROUTE_SEL, 8'h00, q);
    for (int k = 0; k < 3; k++) begin
      seed_a <= {8'h00, 4'(k + 1), 12'h000};
      send(k < 2);
    end
    repeat (20) @(posedge clk);
    #1;
    chk("slot ready when full", 24'(sready), 24'h0);
    bus(1'b0, 1'b1, `TSR_ADDR_STATUS, 8'h00, q);
    chk("status when full", 24'(q), 24'h000002);
    bus(1'b0, 1'b0, 8'h00, 8'h00, q);
    for (int k = 0; k < 3; k++) begin
      take(f);
      chk("buffer order", f.main[0], {8'h00, 4'(k + 1), 12'h001});
    end
    $display("buffer test done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_route();
    t_mask();
    t_ref();
    t_buffer();
    test_done();
  end
endmodule
